// >>> inc/bsc_pkg.sv
// Constants shared by the bit, skip and call execution block
package bsc_pkg;
	// Datapath widths
	localparam int PC_W = 10;
	localparam int DATA_W = 8;
	localparam int FA_W = 6;
	localparam int BIT_W = 3;
	localparam int OP_W = 3;
	localparam int PAGE_W = 2;
	localparam int ADDR_W = 12;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] CMD_OFS = 12'h000;
	localparam logic [ADDR_W-1:0] ACC_OFS = 12'h004;
	localparam logic [ADDR_W-1:0] PAGE_OFS = 12'h008;
	localparam logic [ADDR_W-1:0] TABLE_HIGH_POINTER_OFS = 12'h00c;
	localparam logic [ADDR_W-1:0] PC_OFS = 12'h010;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h014;
	localparam logic [ADDR_W-1:0] STACK_TOP_OFS = 12'h018;
	localparam logic [ADDR_W-1:0] FILE_BASE = 12'h100;
	// Command word field positions
	localparam int CMD_IMM_LSB = 0;
	localparam int CMD_FA_LSB = 8;
	localparam int CMD_BIT_LSB = 14;
	localparam int CMD_OP_LSB = 17;
	localparam int CMD_W = 20;
	// Status word field positions
	localparam int ST_ZERO = 0;
	localparam int ST_SKIP = 1;
	localparam int ST_BUSY = 2;
	localparam int ST_SP_LSB = 8;
	// Reset values
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 10'h000;
	localparam logic [PAGE_W-1:0] PAGE_RST = 2'h0;
	// Operation codes
	localparam logic [OP_W-1:0] OP_NOP = 3'h0;
	localparam logic [OP_W-1:0] OP_AND_IMMEDIATE = 3'h1;
	localparam logic [OP_W-1:0] OP_BIT_SET = 3'h2;
	localparam logic [OP_W-1:0] OP_SKIP_IF_CLEAR = 3'h3;
	localparam logic [OP_W-1:0] OP_SKIP_IF_SET = 3'h4;
	localparam logic [OP_W-1:0] OP_CALL_DIRECT = 3'h5;
	localparam logic [OP_W-1:0] OP_CALL_VIA_ACCUMULATOR = 3'h6;
endpackage : bsc_pkg

// >>> inc/stack_if.sv
// Push port between the executing core and the return stack
`timescale 1ns/10ps
interface stack_if #(
	parameter int SP_W = 2
);
	import bsc_pkg::*;
	logic push;
	logic [PC_W-1:0] push_data;
	logic [SP_W-1:0] sp;
	logic [PC_W-1:0] top_data;
	modport core (output push, output push_data, input sp, input top_data);
	modport stack (input push, input push_data, output sp, output top_data);
endinterface : stack_if

// >>> src/return_stack.sv
// Hardware return stack written at the pointer, then pointer bumped
`timescale 1ns/10ps
module return_stack
	import bsc_pkg::*;
#(
	parameter int DEPTH = 4,
	parameter int SP_W = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Push port
	stack_if.stack st
);
	logic [PC_W-1:0] mem [DEPTH];
	logic [SP_W-1:0] sp_r;

	// Entry at the pointer takes the return address
	always_ff @(posedge clk) begin
		if (st.push) begin
			mem[sp_r] <= st.push_data;
		end
	end

	// Pointer moves up after each push, wrapping when full
	always_ff @(posedge clk) begin
		if (rst) begin
			sp_r <= '0;
		end else if (st.push) begin
			sp_r <= sp_r + 1'b1;
		end
	end

	assign st.sp = sp_r;
	assign st.top_data = mem[sp_r - 1'b1];

	property p_push_order;
		@(posedge clk) disable iff (rst)
		st.push |=> (sp_r == $past(sp_r) + 1'b1)
			&& (mem[$past(sp_r)] == $past(st.push_data));
	endproperty
	a_push_order: assert property (p_push_order)
		else $error("push did not land at old pointer");
endmodule : return_stack

// >>> src/bit_skip_call_execute.sv
// Executes and-immediate, bit-set, bit-test-skip and the two calls
// Behaviour
// - And-immediate: accumulator AND operand, zero flag, one cycle
// - Bit-set forces file bit to one, flags untouched
// - Skip-if-clear skips next when bit is zero
// - Skip-if-set skips next when bit is one
// - Skipped instruction runs as no-operation, one cycle
// - Calls push program counter plus one first
// - Direct call loads page buffer and address
// - Accumulator call loads table pointer and accumulator
`timescale 1ns/10ps
module bit_skip_call_execute
	import bsc_pkg::*;
#(
	parameter int STACK_DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Program counter toward the fetch unit
	output logic [PC_W-1:0] pc_out
);
	localparam int SP_W = $clog2(STACK_DEPTH);

	typedef enum logic [1:0] {IDLE, EXEC, CALL_LOAD, DISCARD} state_t;

	state_t state_r;
	logic [CMD_W-1:0] ir_r;
	logic [DATA_W-1:0] acc_r;
	logic [PAGE_W-1:0] page_r;
	logic [PAGE_W-1:0] table_high_pointer_r;
	logic [PC_W-1:0] pc_r;
	logic [PC_W-1:0] tgt_r;
	logic zero_r;
	logic skip_pend_r;
	logic [DATA_W-1:0] file_mem [2**FA_W];
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] rd_word;
	logic setup;
	logic xfer;
	logic go;
	logic in_file;
	logic tbit;
	logic [OP_W-1:0] op_w;
	logic [DATA_W-1:0] imm_w;
	logic [FA_W-1:0] fa_w;
	logic [BIT_W-1:0] bsel_w;

	stack_if #(.SP_W(SP_W)) st ();

	return_stack #(.DEPTH(STACK_DEPTH), .SP_W(SP_W)) u_stack (
		.clk(clk),
		.rst(rst),
		.st(st.stack)
	);

	// Offsets that answer without error
	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		addr_ok = (a >= FILE_BASE && a < FILE_BASE + 12'h100)
			|| a == CMD_OFS || a == ACC_OFS || a == PAGE_OFS
			|| a == TABLE_HIGH_POINTER_OFS || a == PC_OFS || a == STATUS_OFS
			|| a == STACK_TOP_OFS;
	endfunction : addr_ok

	// Both call flavours share the push and load path
	function automatic logic is_call(input logic [OP_W-1:0] o);
		is_call = (o == OP_CALL_DIRECT) || (o == OP_CALL_VIA_ACCUMULATOR);
	endfunction : is_call

	// Command fields and tested bit
	assign op_w = ir_r[CMD_OP_LSB +: OP_W];
	assign imm_w = ir_r[CMD_IMM_LSB +: DATA_W];
	assign fa_w = ir_r[CMD_FA_LSB +: FA_W];
	assign bsel_w = ir_r[CMD_BIT_LSB +: BIT_W];
	assign tbit = file_mem[fa_w][bsel_w];

	// Bus phases
	assign setup = psel && !penable;
	assign xfer = psel && penable && pready_r;
	assign in_file = paddr >= FILE_BASE;
	assign go = xfer && pwrite && !pslverr_r && paddr == CMD_OFS;

	// Read data selection
	always_comb begin
		rd_word = '0;
		if (in_file) begin
			rd_word[DATA_W-1:0] = file_mem[paddr[FA_W+1:2]];
		end else begin
			case (paddr)
				ACC_OFS: rd_word[DATA_W-1:0] = acc_r;
				PAGE_OFS: rd_word[PAGE_W-1:0] = page_r;
				TABLE_HIGH_POINTER_OFS: rd_word[PAGE_W-1:0] = table_high_pointer_r;
				PC_OFS: rd_word[PC_W-1:0] = pc_r;
				STATUS_OFS: begin
					rd_word[ST_ZERO] = zero_r;
					rd_word[ST_SKIP] = skip_pend_r;
					rd_word[ST_BUSY] = state_r != IDLE;
					rd_word[ST_SP_LSB +: SP_W] = st.sp;
				end
				STACK_TOP_OFS: rd_word[PC_W-1:0] = st.top_data;
				default: rd_word = '0;
			endcase
		end
	end

	// APB answer one cycle after setup; busy command write errors
	always_ff @(posedge clk) begin
		if (rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup && (!addr_ok(paddr)
				|| (pwrite && paddr == CMD_OFS && state_r != IDLE));
			// Unmapped reads, file window overrun included, give zero
			prdata_r <= (setup && !pwrite && addr_ok(paddr))
				? rd_word : '0;
		end
	end

	// Sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= IDLE;
			ir_r <= '0;
		end else begin
			case (state_r)
				IDLE: begin
					if (go) begin
						ir_r <= pwdata[CMD_W-1:0];
						state_r <= skip_pend_r ? DISCARD : EXEC;
					end
				end
				EXEC: state_r <= is_call(op_w) ? CALL_LOAD : IDLE;
				CALL_LOAD: state_r <= IDLE;
				DISCARD: state_r <= IDLE;
				default: state_r <= IDLE;
			endcase
		end
	end

	// Skip flag: set by a test that hits, cleared by the discarded op
	always_ff @(posedge clk) begin
		if (rst) begin
			skip_pend_r <= 1'b0;
		end else if (state_r == EXEC) begin
			skip_pend_r <= (op_w == OP_SKIP_IF_CLEAR && !tbit)
				|| (op_w == OP_SKIP_IF_SET && tbit);
		end else if (state_r == DISCARD) begin
			skip_pend_r <= 1'b0;
		end
	end

	// Accumulator and zero flag
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_r <= ACC_RST;
			zero_r <= 1'b0;
		end else if (state_r == EXEC && op_w == OP_AND_IMMEDIATE) begin
			acc_r <= acc_r & imm_w;
			zero_r <= (acc_r & imm_w) == '0;
		end else if (xfer && pwrite && paddr == ACC_OFS) begin
			acc_r <= pwdata[DATA_W-1:0];
		end
	end

	// Page buffer and table pointer, software written
	always_ff @(posedge clk) begin
		if (rst) begin
			page_r <= PAGE_RST;
			table_high_pointer_r <= PAGE_RST;
		end else if (xfer && pwrite && paddr == PAGE_OFS) begin
			page_r <= pwdata[PAGE_W-1:0];
		end else if (xfer && pwrite && paddr == TABLE_HIGH_POINTER_OFS) begin
			table_high_pointer_r <= pwdata[PAGE_W-1:0];
		end
	end

	// File registers; bit-set lands on top of a same-cycle bus write
	always_ff @(posedge clk) begin
		if (xfer && pwrite && in_file && !pslverr_r) begin
			file_mem[paddr[FA_W+1:2]] <= pwdata[DATA_W-1:0];
		end
		if (state_r == EXEC && op_w == OP_BIT_SET) begin
			file_mem[fa_w][bsel_w] <= 1'b1;
		end
	end

	// Call target captured while the push happens
	always_ff @(posedge clk) begin
		if (rst) begin
			tgt_r <= PC_RST;
		end else if (state_r == EXEC) begin
			tgt_r <= (op_w == OP_CALL_DIRECT) ? {page_r, imm_w}
				: {table_high_pointer_r, acc_r};
		end
	end

	// Program counter
	always_ff @(posedge clk) begin
		if (rst) begin
			pc_r <= PC_RST;
		end else if (state_r == CALL_LOAD) begin
			pc_r <= tgt_r;
		end else if ((state_r == EXEC && !is_call(op_w))
			|| state_r == DISCARD) begin
			pc_r <= pc_r + 1'b1;
		end else if (xfer && pwrite && paddr == PC_OFS) begin
			pc_r <= pwdata[PC_W-1:0];
		end
	end

	// Return address push during the first call cycle
	assign st.push = state_r == EXEC && is_call(op_w);
	assign st.push_data = pc_r + 1'b1;

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pc_out = pc_r;

	property p_and_imm;
		@(posedge clk) disable iff (rst)
		(state_r == EXEC && op_w == OP_AND_IMMEDIATE) |=>
			acc_r == ($past(acc_r) & $past(imm_w))
			&& zero_r == (acc_r == '0) && state_r == IDLE;
	endproperty
	a_and_imm: assert property (p_and_imm)
		else $error("and-immediate result or zero flag wrong");

	property p_bit_set;
		@(posedge clk) disable iff (rst)
		(state_r == EXEC && op_w == OP_BIT_SET) |=>
			file_mem[$past(fa_w)][$past(bsel_w)] && $stable(zero_r);
	endproperty
	a_bit_set: assert property (p_bit_set)
		else $error("bit-set did not set bit or changed flag");

	property p_skip_clear;
		@(posedge clk) disable iff (rst)
		(state_r == EXEC && op_w == OP_SKIP_IF_CLEAR) |=>
			skip_pend_r == !$past(tbit) && $stable(zero_r);
	endproperty
	a_skip_clear: assert property (p_skip_clear)
		else $error("skip-if-clear decision wrong");

	property p_skip_set;
		@(posedge clk) disable iff (rst)
		(state_r == EXEC && op_w == OP_SKIP_IF_SET) |=>
			skip_pend_r == $past(tbit) && $stable(zero_r);
	endproperty
	a_skip_set: assert property (p_skip_set)
		else $error("skip-if-set decision wrong");

	property p_discard;
		@(posedge clk) disable iff (rst)
		(state_r == IDLE && go && skip_pend_r) |=> state_r == DISCARD
			##1 (state_r == IDLE && !skip_pend_r && $stable(acc_r));
	endproperty
	a_discard: assert property (p_discard)
		else $error("skipped instruction was not discarded");

	property p_push_ret;
		@(posedge clk) disable iff (rst)
		(state_r == EXEC && is_call(op_w)) |=>
			st.top_data == $past(pc_r) + 1'b1
			&& st.sp == $past(st.sp) + 1'b1;
	endproperty
	a_push_ret: assert property (p_push_ret)
		else $error("call did not push return address");

	property p_call_direct;
		@(posedge clk) disable iff (rst)
		(state_r == EXEC && op_w == OP_CALL_DIRECT) |=>
			##1 (pc_r == {$past(page_r, 2), $past(imm_w, 2)}
			&& state_r == IDLE);
	endproperty
	a_call_direct: assert property (p_call_direct)
		else $error("direct call target wrong");

	property p_call_acc;
		@(posedge clk) disable iff (rst)
		(state_r == EXEC && op_w == OP_CALL_VIA_ACCUMULATOR) |=>
			##1 (pc_r == {$past(table_high_pointer_r, 2), $past(acc_r, 2)}
			&& state_r == IDLE);
	endproperty
	a_call_acc: assert property (p_call_acc)
		else $error("accumulator call target wrong");
endmodule : bit_skip_call_execute

// >>> verification/fetch_model.sv
// Program memory fetch model that follows the program counter
`timescale 1ns/10ps
module fetch_model
	import bsc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Program counter from the core
	input wire logic [PC_W-1:0] pc,
	// Fetches seen since reset
	output logic [15:0] fetch_count
);
	logic [PC_W-1:0] last_pc_r;
	// New fetch whenever the counter moves
	always_ff @(posedge clk) begin
		if (rst) begin
			fetch_count <= 16'h0;
			last_pc_r <= '0;
		end else if (pc !== last_pc_r) begin
			fetch_count <= fetch_count + 16'h1;
			last_pc_r <= pc;
		end
	end
endmodule : fetch_model

// >>> verification/bit_skip_call_execute_tb.sv
// Self-checking bench for the bit, skip and call execution block
`timescale 1ns/10ps
module bit_skip_call_execute_tb;
	import bsc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [PC_W-1:0] pc_out;
	logic [15:0] fetch_count;
	logic [31:0] rd;
	logic er;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	// Rows: command, register read after it, expected word
	logic [31:0] row_cmd [10] = '{32'h200af, 32'h20000, 32'h48500,
		32'h5c500, 32'h60500, 32'h40500, 32'h84500, 32'h40500,
		32'h80500, 32'h64500};
	logic [ADDR_W-1:0] row_addr [10] = '{12'h004, 12'h014, 12'h114,
		12'h014, 12'h014, 12'h114, 12'h014, 12'h114, 12'h014, 12'h014};
	logic [31:0] row_exp [10] = '{32'h0a, 32'h1, 32'h5e, 32'h1, 32'h3,
		32'hde, 32'h3, 32'hde, 32'h1, 32'h1};

	// Clock
	always #5 clk = ~clk;

	// Device under test and fetch side
	bit_skip_call_execute #(.STACK_DEPTH(4)) u_dut (.clk(clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pc_out(pc_out));
	fetch_model u_fetch (.clk(clk), .rst(rst), .pc(pc_out),
		.fetch_count(fetch_count));

	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer, held until pready is seen at a rising edge
	task apb(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Report and end
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			summarize();
		end
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({22'h0, pc_out}, 32'h0);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, ACC_OFS, 32'h5a);
		apb(1'b1, FILE_BASE + 12'h014, 32'h5a);
		// Ordinary operations, skips and discards
		for (int i = 0; i < 10; i++) begin
			apb(1'b1, CMD_OFS, row_cmd[i]);
			apb(1'b0, row_addr[i], 32'h0);
			chk(rd, row_exp[i]);
		end
		apb(1'b0, PC_OFS, 32'h0);
		chk(rd, 32'h00a);
		// Discarded ops still move the counter, one fetch each
		chk({16'h0, fetch_count}, 32'h00a);
		// Direct call
		apb(1'b1, PC_OFS, 32'h0a0);
		apb(1'b1, PAGE_OFS, 32'h1);
		apb(1'b1, CMD_OFS, 32'ha0034);
		apb(1'b0, STACK_TOP_OFS, 32'h0);
		chk(rd, 32'h0a1);
		chk({22'h0, pc_out}, 32'h134);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk({30'h0, rd[9:8]}, 32'h1);
		// Accumulator call, pointer upper bits ignored
		apb(1'b1, ACC_OFS, 32'h34);
		apb(1'b1, TABLE_HIGH_POINTER_OFS, 32'h6);
		apb(1'b1, CMD_OFS, 32'hc0000);
		apb(1'b0, STACK_TOP_OFS, 32'h0);
		chk(rd, 32'h135);
		chk({22'h0, pc_out}, 32'h234);
		// Status is read-only, unmapped space errors
		apb(1'b1, STATUS_OFS, 32'hffff);
		chk({31'h0, er}, 32'h0);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk({30'h0, rd[9:8]}, 32'h2);
		apb(1'b0, 12'h020, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		// Second reset in mid-run
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({22'h0, pc_out}, 32'h0);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk(rd, 32'h0);
		summarize();
	end
endmodule : bit_skip_call_execute_tb
